// ==== rtl/chg_pin_pkg.sv ====
/*
 * shared constants and carriers of the charger pin control block:
 * register offsets, field layouts, reset values, timing figures, state codes.
 * assumes a 100 MHz core clock; all pin inputs are asynchronous to it.
 */
package chg_pin_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_CURRENT_CAP_RESISTOR_PIN = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_DRIVE = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h0C;
    localparam int CTRL_DET_BIT = 4;
    localparam int CTRL_SHIP_BIT = 5;
    localparam int LVL_W = 3;
    localparam int DM_LSB = 4;
    localparam int CAP_W = 6;

    typedef struct packed {
        logic pin_limit_use_bit;
        logic indicator_mute_bit;
        logic boost_allow_bit;
        logic charge_allow_bit;
    } ctrl_t;
    localparam ctrl_t CTRL_RST = 4'h1;
    localparam logic [CAP_W-1:0] CAP_RST = 6'h08;

    typedef enum logic [1:0] {
        SRC_SDP = 2'h0,
        SRC_CDP = 2'h1,
        SRC_DCP = 2'h2,
        SRC_HIGH_VOLT_DEDICATED_PORT = 2'h3
    } src_t;

    typedef struct packed {
        src_t det_result;
        logic det_busy;
        logic dline_switch_ctrl;
        logic ship_mode;
        logic battery_switch;
        logic boost_en;
        logic charge_en;
        logic fault;
        logic done;
        logic charging;
    } status_t;

    // gray codes along idle, contact, primary, secondary, high volt, done
    typedef enum logic [2:0] {
        DET_IDLE = 3'h0,
        DET_DCD = 3'h1,
        DET_PRI = 3'h3,
        DET_SEC = 3'h2,
        DET_HV = 3'h6,
        DET_DONE = 3'h7
    } det_t;

    // ----------------------------------------------------------------
    // pin synchroniser slots
    // ----------------------------------------------------------------
    localparam int PIN_N = 11;
    localparam int P_BOOST = 0;
    localparam int P_CE_N = 1;
    localparam int P_BTN_N = 2;
    localparam int P_DONE = 3;
    localparam int P_FAULT = 4;
    localparam int P_VBUS = 5;
    localparam int P_TS_OK = 6;
    localparam int P_DCD = 7;
    localparam int P_DMCMP = 8;
    localparam int P_DPCMP = 9;
    localparam int P_HVACK = 10;
    // button and charge pin reset high, the button as its pull-up makes it
    localparam logic [PIN_N-1:0] PIN_RST = 11'h006;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned BLINK_HALF_MS = 500;
    localparam int unsigned ALERT_US = 256;
    localparam int unsigned WAKE_HOLD_MS = 1000;
    localparam int unsigned RESET_HOLD_MS = 15000;
    localparam int unsigned SWITCH_OFF_MS = 300;
    localparam int unsigned DET_STEP_MS = 40;
    localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
    localparam int unsigned ALERT_CYC = ALERT_US * (CLK_HZ / 1000000);
    localparam int unsigned WAKE_HOLD_CYC = WAKE_HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned SWITCH_OFF_CYC = SWITCH_OFF_MS * (CLK_HZ / 1000);
    localparam int unsigned DET_STEP_CYC = DET_STEP_MS * (CLK_HZ / 1000);
endpackage

// ==== rtl/chg_pin_ctrl.sv ====
/*
 * charger pin control: indicator, host alert, charge and boost qualifiers,
 * input current cap selection, wake/reset button timing, adapter detection
 * sequencing with data-line switch control, and an avalon-mm register slave.
 * assumes analog comparators and pads outside; pads resolve open-drain levels.
 */
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/10ps

// How it works
// [R1] indicator pulled low while charging, released when done or disabled
// [R2] any fault makes the indicator blink at one cycle per second
// [R3] mute bit releases the indicator entirely
// [R4] status change or fault sends one 256 us low alert pulse
// [R5] boost only when boost allow bit is 1 and boost pin high
// [R6] charging only when charge allow bit is 1 and charge pin low
// [R7] board keeps the charge pin at a defined level, never floating
// [R8] current cap is the smaller of pin cap and programmed field
// [R9] with pin limit use bit 0 the pin cap is ignored
// [R10] in ship mode, button held low one second closes the battery switch
// [R11] no supply, button low fifteen seconds opens switch 0.3 s then recloses
// [R12] button input reads high when undriven
// [R13] data-line switch control rests low, high during detection
// [R14] after detection it stays high for dedicated ports, low for SDP or CDP
// [R15] detection runs contact, primary, secondary, then high-voltage steps
// [R16] D+ and D- driven at field levels only with supply or boost active
// [R17] charging suspends while the thermistor is out of window
// [R18] a short button press does nothing; timing restarts each falling edge
// [R19] events during a pulse merge into one waiting pulse, never a new one before the last ends
module chg_pin_ctrl import chg_pin_pkg::*; #(
    parameter int unsigned BLINK_HALF = BLINK_HALF_CYC,
    parameter int unsigned ALERT_LEN = ALERT_CYC,
    parameter int unsigned WAKE_HOLD = WAKE_HOLD_CYC,
    parameter int unsigned RESET_HOLD = RESET_HOLD_CYC,
    parameter int unsigned SWITCH_OFF = SWITCH_OFF_CYC,
    parameter int unsigned DET_STEP = DET_STEP_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // asynchronous pins and comparator levels
    input wire logic [PIN_N-1:0] pins_in,
    input wire logic [CAP_W-1:0] current_cap_resistor_pin,
    // open-drain indicator and alert, oe low while pulling low
    output logic stat_o,
    output logic stat_oe_n,
    output logic alert_o,
    output logic alert_oe_n,
    // D+ / D- drivers, oe low while driving
    output logic [LVL_W-1:0] dplus_level,
    output logic dplus_oe_n,
    output logic [LVL_W-1:0] dminus_level,
    output logic dminus_oe_n,
    // power stage controls
    output logic charge_en_r,
    output logic boost_en_r,
    output logic [CAP_W-1:0] input_cap_r,
    output logic battery_switch_r,
    output logic dline_switch_ctrl
);
    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    logic [PIN_N-1:0] meta_r, pin_s;
    logic [CAP_W-1:0] cap_meta_r, cap_s;
    for (genvar i = 0; i < PIN_N; i++) begin : g_sync
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                meta_r[i] <= PIN_RST[i]; // R12
                pin_s[i] <= PIN_RST[i]; // R12
            end else begin
                meta_r[i] <= pins_in[i];
                pin_s[i] <= meta_r[i];
            end
        end
    end
    // cap code is quasi-static, sampled like any pin
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cap_meta_r <= '0;
            cap_s <= '0;
        end else begin
            cap_meta_r <= current_cap_resistor_pin;
            cap_s <= cap_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // registers and bus slave
    // ----------------------------------------------------------------
    ctrl_t ctrl_r;
    logic [CAP_W-1:0] cap_field_r;
    logic [LVL_W-1:0] dp_lvl_r, dm_lvl_r;
    logic det_go_r, ship_go_r;
    status_t status;
    logic wr_ok;
    assign wr_ok = write && !waitrequest;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            waitrequest <= 1'b1;
            readdata <= '0;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
            case (address)
                ADDR_CTRL: readdata <= {28'h0, ctrl_r};
                ADDR_CURRENT_CAP_RESISTOR_PIN: readdata <= {26'h0, cap_field_r};
                ADDR_DRIVE: readdata <= {25'h0, dm_lvl_r, 1'b0, dp_lvl_r};
                ADDR_STATUS: readdata <= {21'h0, status};
                default: readdata <= '0;
            endcase
        end else begin
            waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= CTRL_RST;
            cap_field_r <= CAP_RST;
            dp_lvl_r <= '0;
            dm_lvl_r <= '0;
            det_go_r <= 1'b0;
            ship_go_r <= 1'b0;
        end else begin
            det_go_r <= wr_ok && address == ADDR_CTRL && writedata[CTRL_DET_BIT];
            ship_go_r <= wr_ok && address == ADDR_CTRL && writedata[CTRL_SHIP_BIT];
            if (wr_ok && address == ADDR_CTRL) begin
                ctrl_r <= writedata[$bits(ctrl_t)-1:0];
            end
            if (wr_ok && address == ADDR_CURRENT_CAP_RESISTOR_PIN) begin
                cap_field_r <= writedata[CAP_W-1:0];
            end
            if (wr_ok && address == ADDR_DRIVE) begin
                dp_lvl_r <= writedata[LVL_W-1:0];
                dm_lvl_r <= writedata[DM_LSB +: LVL_W];
            end
        end
    end

    // ----------------------------------------------------------------
    // charge, boost and current cap qualifiers
    // ----------------------------------------------------------------
    // the charge pin has no pull of its own here; a floating pin is a board fault
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            charge_en_r <= 1'b0;
            boost_en_r <= 1'b0;
            input_cap_r <= CAP_RST;
        end else begin
            charge_en_r <= ctrl_r.charge_allow_bit && !pin_s[P_CE_N] // R6 R7
                && pin_s[P_TS_OK]; // R17
            boost_en_r <= ctrl_r.boost_allow_bit && pin_s[P_BOOST]; // R5
            if (ctrl_r.pin_limit_use_bit && cap_s < cap_field_r) begin
                input_cap_r <= cap_s; // R8
            end else begin
                input_cap_r <= cap_field_r; // R9
            end
        end
    end

    // ----------------------------------------------------------------
    // charge indicator
    // ----------------------------------------------------------------
    logic [31:0] blink_cnt_r;
    logic blink_r, charging;
    assign charging = charge_en_r && !pin_s[P_DONE];
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            blink_cnt_r <= '0;
            blink_r <= 1'b0;
        end else if (!pin_s[P_FAULT]) begin
            blink_cnt_r <= '0;
            blink_r <= 1'b0;
        end else if (blink_cnt_r == BLINK_HALF - 1) begin
            blink_cnt_r <= '0;
            blink_r <= !blink_r; // R2
        end else begin
            blink_cnt_r <= blink_cnt_r + 32'h1;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_oe_n <= 1'b1;
        end else if (ctrl_r.indicator_mute_bit) begin
            stat_oe_n <= 1'b1; // R3
        end else if (pin_s[P_FAULT]) begin
            stat_oe_n <= !blink_r; // R2
        end else begin
            stat_oe_n <= !charging; // R1
        end
    end
    assign stat_o = 1'b0;
    assign alert_o = 1'b0;

    // ----------------------------------------------------------------
    // host alert
    // ----------------------------------------------------------------
    logic [3:0] evt_q_r;
    logic evt, pend_r;
    logic [31:0] alert_cnt_r;
    assign evt = {charging, pin_s[P_DONE], pin_s[P_FAULT], status.det_busy} != evt_q_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            evt_q_r <= '0;
            pend_r <= 1'b0;
            alert_cnt_r <= '0;
            alert_oe_n <= 1'b1;
        end else begin
            evt_q_r <= {charging, pin_s[P_DONE], pin_s[P_FAULT], status.det_busy};
            if (alert_oe_n && (pend_r || evt)) begin
                alert_oe_n <= 1'b0; // R4
                alert_cnt_r <= '0;
                pend_r <= 1'b0;
            end else begin
                // an event during a pulse waits; one in the cycle a waiting pulse starts is merged into it
                if (evt) begin
                    pend_r <= 1'b1; // R19
                end
                if (!alert_oe_n) begin
                    if (alert_cnt_r == ALERT_LEN - 1) begin
                        alert_oe_n <= 1'b1; // R4
                    end
                    alert_cnt_r <= alert_cnt_r + 32'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // wake / reset button and battery switch
    // ----------------------------------------------------------------
    logic [31:0] btn_cnt_r, off_cnt_r;
    logic ship_r, fired_r, off_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            btn_cnt_r <= '0;
            fired_r <= 1'b0;
        end else if (pin_s[P_BTN_N]) begin
            btn_cnt_r <= '0; // R18
            fired_r <= 1'b0;
        end else if (!fired_r) begin
            btn_cnt_r <= btn_cnt_r + 32'h1;
            fired_r <= (ship_r && btn_cnt_r == WAKE_HOLD - 1)
                || (!ship_r && !pin_s[P_VBUS] && btn_cnt_r == RESET_HOLD - 1);
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ship_r <= 1'b0;
            off_r <= 1'b0;
            off_cnt_r <= '0;
            battery_switch_r <= 1'b1;
        end else begin
            if (ship_go_r) begin
                ship_r <= 1'b1;
            end else if (ship_r && !fired_r && !pin_s[P_BTN_N]
                && btn_cnt_r == WAKE_HOLD - 1) begin
                ship_r <= 1'b0; // R10
            end
            if (!ship_r && !fired_r && !pin_s[P_BTN_N] && !pin_s[P_VBUS]
                && btn_cnt_r == RESET_HOLD - 1) begin
                off_r <= 1'b1; // R11
                off_cnt_r <= '0;
            end else if (off_r) begin
                if (off_cnt_r == SWITCH_OFF - 1) begin
                    off_r <= 1'b0; // R11
                end
                off_cnt_r <= off_cnt_r + 32'h1;
            end
            battery_switch_r <= !ship_r && !off_r;
        end
    end

    // ----------------------------------------------------------------
    // adapter detection and data lines
    // ----------------------------------------------------------------
    det_t det_r;
    src_t res_r;
    logic [31:0] step_r;
    logic vbus_q_r, step_end;
    assign step_end = step_r == DET_STEP - 1;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            det_r <= DET_IDLE;
            res_r <= SRC_SDP;
            step_r <= '0;
            vbus_q_r <= 1'b0;
        end else begin
            vbus_q_r <= pin_s[P_VBUS];
            step_r <= (det_r == DET_IDLE || det_r == DET_DONE || step_end) ? '0
                : step_r + 32'h1;
            case (det_r) // R15
                DET_IDLE, DET_DONE: begin
                    if ((pin_s[P_VBUS] && !vbus_q_r) || det_go_r) begin
                        det_r <= DET_DCD;
                    end else if (!pin_s[P_VBUS]) begin
                        det_r <= DET_IDLE;
                    end
                end
                DET_DCD: begin
                    if (pin_s[P_DCD] || step_end) begin
                        det_r <= DET_PRI;
                    end
                end
                DET_PRI: begin
                    if (step_end) begin
                        res_r <= SRC_SDP;
                        det_r <= pin_s[P_DMCMP] ? DET_SEC : DET_DONE;
                    end
                end
                DET_SEC: begin
                    if (step_end) begin
                        res_r <= pin_s[P_DPCMP] ? SRC_DCP : SRC_CDP;
                        det_r <= pin_s[P_DPCMP] ? DET_HV : DET_DONE;
                    end
                end
                DET_HV: begin
                    if (pin_s[P_HVACK]) begin
                        res_r <= SRC_HIGH_VOLT_DEDICATED_PORT;
                        det_r <= DET_DONE;
                    end else if (step_end) begin
                        det_r <= DET_DONE;
                    end
                end
                default: det_r <= DET_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dline_switch_ctrl <= 1'b0;
            dplus_oe_n <= 1'b1;
            dminus_oe_n <= 1'b1;
            dplus_level <= '0;
            dminus_level <= '0;
        end else begin
            dline_switch_ctrl <= (det_r != DET_IDLE && det_r != DET_DONE) // R13
                || (det_r == DET_DONE && res_r[1]); // R14
            // the contact step owns the lines; user levels in every other state while supply or boost is present
            dplus_oe_n <= !((pin_s[P_VBUS] || boost_en_r) && det_r != DET_DCD); // R16
            dminus_oe_n <= !((pin_s[P_VBUS] || boost_en_r) && det_r != DET_DCD); // R16
            dplus_level <= dp_lvl_r;
            dminus_level <= dm_lvl_r;
        end
    end

    assign status = '{det_result: res_r, det_busy: det_r != DET_IDLE && det_r != DET_DONE,
        dline_switch_ctrl: dline_switch_ctrl, ship_mode: ship_r,
        battery_switch: battery_switch_r, boost_en: boost_en_r, charge_en: charge_en_r,
        fault: pin_s[P_FAULT], done: pin_s[P_DONE], charging: charging};

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_stat_mute_release: assert property ($past(ctrl_r.indicator_mute_bit) |-> stat_oe_n) // R3
        else $error("indicator driven while muted");
    a_stat_charge_low: assert property ($past(!ctrl_r.indicator_mute_bit && !pin_s[P_FAULT]
        && charging) |-> !stat_oe_n) // R1
        else $error("indicator not low while charging");
    a_stat_blink_level: assert property ($past(!ctrl_r.indicator_mute_bit && pin_s[P_FAULT])
        |-> stat_oe_n == !$past(blink_r)) // R2
        else $error("indicator not following blink");
    a_alert_pulse_len: assert property ($rose(alert_oe_n)
        |-> $past(alert_cnt_r) == ALERT_LEN - 1) // R4
        else $error("alert pulse length wrong");
    a_alert_no_overlap: assert property (!alert_oe_n && $past(!alert_oe_n)
        |-> alert_cnt_r == $past(alert_cnt_r) + 32'h1) // R19
        else $error("alert pulse restarted");
    a_boost_qualify: assert property (boost_en_r == $past(ctrl_r.boost_allow_bit
        && pin_s[P_BOOST])) // R5
        else $error("boost qualifier wrong");
    a_charge_qualify: assert property (charge_en_r |-> $past(ctrl_r.charge_allow_bit
        && !pin_s[P_CE_N] && pin_s[P_TS_OK])) // R6
        else $error("charging without qualification");
    a_cap_min_sel: assert property (input_cap_r <= $past(cap_field_r)) // R8
        else $error("current cap above field");
    a_cap_pin_ignore: assert property ($past(!ctrl_r.pin_limit_use_bit)
        |-> input_cap_r == $past(cap_field_r)) // R9
        else $error("pin cap used while disabled");
    a_dline_switch_ctrl_detect_high: assert property (det_r == DET_PRI |=> dline_switch_ctrl) // R13
        else $error("dline switch low during detection");
    a_dline_switch_ctrl_result_low: assert property (det_r == DET_DONE && !res_r[1]
        && $past(det_r == DET_DONE) |=> !dline_switch_ctrl) // R14
        else $error("dline switch high after SDP or CDP");
    a_dline_released: assert property ($past(!pin_s[P_VBUS] && !boost_en_r)
        |-> dplus_oe_n && dminus_oe_n) // R16
        else $error("data line driven without supply or boost");
    a_short_press_none: assert property (pin_s[P_BTN_N] |=> btn_cnt_r == 32'h0) // R18
        else $error("button timing not restarted");

    c_fault_blink: cover property (pin_s[P_FAULT] && $rose(blink_r));
    c_alert_pulse: cover property ($rose(alert_oe_n));
    c_hv_found: cover property (det_r == DET_DONE && res_r == SRC_HIGH_VOLT_DEDICATED_PORT);
    c_ship_wake: cover property ($fell(ship_r));
endmodule

// ==== test/far_side_model.sv ====
/*
 * far-side model: charge strap, boost request, push button, comparator
 * levels and the board pull-ups on the open-drain indicator and alert.
 * assumes the bench moves its knobs just after rising clock edges.
 */
`timescale 1ns/10ps
module far_side_model import chg_pin_pkg::*; (
    // knobs from the bench
    input wire logic press,
    input wire logic ce_low,
    input wire logic [8:0] misc,
    // open-drain pads of the block
    input wire logic stat_o,
    input wire logic stat_oe_n,
    input wire logic alert_o,
    input wire logic alert_oe_n,
    // levels seen on the board
    output logic [PIN_N-1:0] pins_in,
    output logic stat_line,
    output logic alert_line
);
    // the button only ever pulls low; released, the pad pull-up wins
    assign pins_in[P_BTN_N] = press ? 1'b0 : 1'b1;
    assign pins_in[P_CE_N] = ce_low ? 1'b0 : 1'b1;
    assign pins_in[P_BOOST] = misc[0];
    assign pins_in[PIN_N-1:P_DONE] = misc[8:1];
    // ----
    // board pull-ups
    // ----
    assign stat_line = stat_oe_n ? 1'b1 : stat_o;
    assign alert_line = alert_oe_n ? 1'b1 : alert_o;
endmodule

// ==== test/chg_pin_ctrl_tb.sv ====
/*
 * bench of the charger pin block: avalon master, random and corner checks.
 * assumes shortened timing parameters and one 100 MHz clock.
 */
`timescale 1ns/10ps
module chg_pin_ctrl_tb import chg_pin_pkg::*;;
    logic clk, arst_n, read, write, waitrequest, press, ce_low;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata, readdata, q;
    logic [8:0] misc;
    logic [PIN_N-1:0] pins_in;
    logic [CAP_W-1:0] current_cap_resistor_pin, input_cap_r, f;
    logic stat_o, stat_oe_n, alert_o, alert_oe_n, stat_line, alert_line;
    logic charge_en_r, boost_en_r, battery_switch_r, dline_switch_ctrl;
    logic dplus_oe_n, dminus_oe_n;
    logic [LVL_W-1:0] dplus_level, dminus_level;
    logic [3:0] c;
    logic [3:0] pat [3] = '{4'h1, 4'h7, 4'hF};
    int fail_count = 0, n_compared = 0, cyc = 0, n;

    chg_pin_ctrl #(.BLINK_HALF(20), .ALERT_LEN(8), .WAKE_HOLD(30), .RESET_HOLD(60),
        .SWITCH_OFF(10), .DET_STEP(10)) chg_pin_ctrl_inst (.*);
    far_side_model far_side_model_inst (.*);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ceiling well above the roughly 900 cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // an idle edge first, so a release is never overwritten in its own step
    task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task wt(input int m);
        repeat (m) @(posedge clk);
    endtask
    // length of the next run at level v on the alert (sel) or indicator line
    task runlen(input logic sel, input logic v);
        n = 0;
        while ((sel ? alert_line : stat_line) !== v && n < 50) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while ((sel ? alert_line : stat_line) === v && n < 50) begin
            @(posedge clk);
            n++;
        end
    endtask
    function automatic logic [31:0] cap_exp(logic u, logic [CAP_W-1:0] p, logic [CAP_W-1:0] v);
        return {26'h0, (u && p < v) ? p : v};
    endfunction
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        arst_n = 1'b0;
        {read, write, press, ce_low} = 4'h0;
        address = '0;
        writedata = '0;
        misc = 9'h010;
        current_cap_resistor_pin = 6'h3F;
        n = $urandom(94181);
        wt(20);
        arst_n <= 1'b1;
        bus(0, ADDR_CTRL, 0);
        chk(q, 32'h1);
        bus(0, ADDR_CURRENT_CAP_RESISTOR_PIN, 0);
        chk(q, 32'h8);
        bus(0, 5'h10, 0);
        chk(q, 32'h0);
        chk(dline_switch_ctrl, 1'b0);
        chk({dplus_oe_n, dminus_oe_n}, 2'h3);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            c = 4'($urandom) & 4'hB;
            f = 6'($urandom);
            ce_low <= 1'($urandom);
            misc[0] <= 1'($urandom);
            misc[4] <= 1'($urandom);
            current_cap_resistor_pin <= 6'($urandom);
            bus(1, ADDR_CURRENT_CAP_RESISTOR_PIN, {26'h0, f});
            bus(1, ADDR_CTRL, {28'h0, c});
            wt(4);
            chk(charge_en_r, c[0] & ce_low & misc[4]);
            chk(boost_en_r, c[1] & misc[0]);
            chk(input_cap_r, cap_exp(c[3], current_cap_resistor_pin, f));
        end
        $display("test qualifiers done");
        ce_low <= 1'b1;
        misc[4] <= 1'b1;
        bus(1, ADDR_CTRL, 32'h1);
        wt(5);
        chk(stat_line, 1'b0);
        misc[1] <= 1'b1;
        wt(5);
        chk(stat_line, 1'b1);
        misc[1] <= 1'b0;
        bus(1, ADDR_CTRL, 32'h5);
        wt(4);
        chk(stat_line, 1'b1);
        bus(1, ADDR_CTRL, 32'h1);
        wt(40);
        misc[2] <= 1'b1;
        runlen(1, 0);
        chk(n, 8);
        runlen(1, 1);
        chk(n, 50);
        runlen(0, 0);
        chk(n, 20);
        runlen(0, 1);
        chk(n, 20);
        misc[2] <= 1'b0;
        wt(40);
        $display("test indicator done");
        bus(1, ADDR_CTRL, 32'h21);
        wt(3);
        chk(battery_switch_r, 1'b0);
        press <= 1'b1;
        wt(15);
        press <= 1'b0;
        wt(40);
        chk(battery_switch_r, 1'b0);
        press <= 1'b1;
        wt(25);
        chk(battery_switch_r, 1'b0);
        wt(11);
        chk(battery_switch_r, 1'b1);
        press <= 1'b0;
        wt(5);
        press <= 1'b1;
        wt(66);
        chk(battery_switch_r, 1'b0);
        wt(12);
        chk(battery_switch_r, 1'b1);
        press <= 1'b0;
        $display("test button done");
        // supply present, so a dedicated port result is kept after detection
        misc[3] <= 1'b1;
        f = 6'($urandom);
        bus(1, ADDR_DRIVE, {25'h0, f[5:3], 1'b0, f[2:0]});
        wt(40);
        bus(0, ADDR_DRIVE, 0);
        chk(q, {25'h0, f[5:3], 1'b0, f[2:0]});
        for (int i = 0; i < 3; i++) begin
            misc[8:5] <= pat[i];
            bus(1, ADDR_CTRL, 32'h11);
            wt(4);
            chk(dline_switch_ctrl, 1'b1);
            wt(60);
            bus(0, ADDR_STATUS, 0);
            chk(q[10:9], (i == 0) ? 0 : i + 1);
            chk(dline_switch_ctrl, i != 0);
            chk({dplus_oe_n, dminus_oe_n}, 2'h0);
            chk({dminus_level, dplus_level}, f);
        end
        $display("test detection done");
        finish_test();
    end
endmodule
